// ### common/acf_params.svh
// offsets, field positions, reset values and masks of the clear vector bank
// assumes byte-wide register port, one clock, active-high async reset
//
// What this block does
// - four byte locations hold 32-bit clear vector
// - bits 29-24 start user application sequences
// - bit 23 starts control application sequence
// - bits 22-19 start user application sequences
// - bit 18 starts wake/sleep application sequence
// - bit 16 starts event queue sequence
// - bit 15 starts sample queue sequence
// - bit 14 starts frame counting sequence
// - bits 13-12 start user application sequences
// - bits 11-8 start tilt, tap, accel sequences
// - bits 7-6 start orientation, front-end sequences
// - bits 4-1 start mailbox, pin, parser, scheduler
// - bit 0 starts every application's sequence
// - power-on reset or wake clears flags
// - host general or own bit clears flag
`ifndef ACF_PARAMS_SVH
`define ACF_PARAMS_SVH

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define ACF_OFS_BYTE3 8'h08
`define ACF_OFS_BYTE2 8'h09
`define ACF_OFS_BYTE1 8'h10
`define ACF_OFS_BYTE0 8'h11

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define ACF_RST_BYTE3 8'hFF
`define ACF_RST_BYTE2 8'h7F
`define ACF_RST_BYTE1 8'hFF
`define ACF_RST_BYTE0 8'hFF

// -----------------------------------------------------------------
// field positions and masks
// -----------------------------------------------------------------
`define ACF_BIT_GENERAL    0
`define ACF_BIT_SCHEDULER  1
`define ACF_BIT_CMD_PARSER 2
`define ACF_BIT_GPIO       3
`define ACF_BIT_MSG_BOX    4
`define ACF_BIT_FRONT_END  6
`define ACF_BIT_ORIENT     7
`define ACF_BIT_HIGH_ACCEL 8
`define ACF_BIT_LOW_ACCEL  9
`define ACF_BIT_TAP        10
`define ACF_BIT_TILT       11
`define ACF_BIT_FRAME_CNT  14
`define ACF_BIT_SAMPLE_Q   15
`define ACF_BIT_EVENT_Q    16
`define ACF_BIT_WAKE_SLEEP 18
`define ACF_BIT_SELF       23
`define ACF_USER_TOP_HI    29
`define ACF_USER_TOP_LO    24
`define ACF_USER_MID_HI    22
`define ACF_USER_MID_LO    19
`define ACF_USER_LOW_HI    13
`define ACF_USER_LOW_LO    12
`define ACF_VALID_MASK     32'h3FFD_FFDF

`endif

// ### common/acf_pkg.sv
// types shared by the clear vector bank
// assumes acf_params.svh carries the numbers
package acf_pkg;

    // -----------------------------------------------------------------
    // register selection
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        ACF_SEL_NONE,
        ACF_SEL_BYTE3,
        ACF_SEL_BYTE2,
        ACF_SEL_BYTE1,
        ACF_SEL_BYTE0
    } acf_sel_t;

    typedef logic [31:0] acf_vec_t;

endpackage : acf_pkg

// ### rtl/acf_clear_bank.sv
// clear vector bank: four byte registers that start per-application sequences
// assumes a single-cycle strobe register port and application flag-set pulses
`timescale 1ns/1ps
`include "acf_params.svh"

module acf_clear_bank #(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [31:0]       app_flag_set,
    input  wire logic              wake_event,
    output logic      [7:0]        reg_rdata,
    output logic      [31:0]       seq_start,
    output logic      [31:0]       app_flag
);

    // -----------------------------------------------------------------
    // decode
    // -----------------------------------------------------------------
    function automatic acf_pkg::acf_sel_t acf_decode(input logic [ADDR_W-1:0] a);
        acf_pkg::acf_sel_t s;
        s = acf_pkg::ACF_SEL_NONE;
        if (a == ADDR_W'(`ACF_OFS_BYTE3)) s = acf_pkg::ACF_SEL_BYTE3;
        if (a == ADDR_W'(`ACF_OFS_BYTE2)) s = acf_pkg::ACF_SEL_BYTE2;
        if (a == ADDR_W'(`ACF_OFS_BYTE1)) s = acf_pkg::ACF_SEL_BYTE1;
        if (a == ADDR_W'(`ACF_OFS_BYTE0)) s = acf_pkg::ACF_SEL_BYTE0;
        return s;
    endfunction : acf_decode

    // -----------------------------------------------------------------
    // byte lane helpers
    // -----------------------------------------------------------------
    function automatic acf_pkg::acf_vec_t acf_lane_place(input acf_pkg::acf_sel_t s, input logic [7:0] d);
        acf_pkg::acf_vec_t v;
        v = 32'h0000_0000;
        unique case (s)
            acf_pkg::ACF_SEL_BYTE3: v[31:24] = d;
            acf_pkg::ACF_SEL_BYTE2: v[23:16] = d;
            acf_pkg::ACF_SEL_BYTE1: v[15:8]  = d;
            acf_pkg::ACF_SEL_BYTE0: v[7:0]   = d;
            default:                v        = 32'h0000_0000;
        endcase
        return v;
    endfunction : acf_lane_place

    function automatic logic [7:0] acf_lane_pick(input acf_pkg::acf_sel_t s, input acf_pkg::acf_vec_t v);
        logic [7:0] b;
        b = 8'h00;
        unique case (s)
            acf_pkg::ACF_SEL_BYTE3: b = v[31:24];
            acf_pkg::ACF_SEL_BYTE2: b = v[23:16];
            acf_pkg::ACF_SEL_BYTE1: b = v[15:8];
            acf_pkg::ACF_SEL_BYTE0: b = v[7:0];
            default:                b = 8'h00;
        endcase
        return b;
    endfunction : acf_lane_pick

    // -----------------------------------------------------------------
    // signals
    // -----------------------------------------------------------------
    acf_pkg::acf_sel_t sel;
    logic              wr_byte3;
    logic              wr_byte2;
    logic              wr_byte1;
    logic              wr_byte0;
    logic [7:0]        clear_vector_byte3_reg;
    logic [7:0]        clear_vector_byte3_next;
    logic [7:0]        clear_vector_byte2_reg;
    logic [7:0]        clear_vector_byte2_next;
    logic [7:0]        clear_vector_byte1_reg;
    logic [7:0]        clear_vector_byte1_next;
    logic [7:0]        clear_vector_byte0_reg;
    logic [7:0]        clear_vector_byte0_next;
    acf_pkg::acf_vec_t vec_reg;
    acf_pkg::acf_vec_t wr_ones;
    logic              general_wr;
    acf_pkg::acf_vec_t start_req;
    logic [5:0]        start_user_top;
    logic              start_self;
    logic [3:0]        start_user_mid;
    logic              start_wake_sleep;
    logic              start_event_q;
    logic              start_sample_q;
    logic              start_frame_cnt;
    logic [1:0]        start_user_low;
    logic              start_tilt;
    logic              start_tap;
    logic              start_low_accel;
    logic              start_high_accel;
    logic              start_orient;
    logic              start_front_end;
    logic              start_msg_box;
    logic              start_gpio;
    logic              start_cmd_parser;
    logic              start_scheduler;
    logic              start_general;
    acf_pkg::acf_vec_t start_next;
    acf_pkg::acf_vec_t start_reg;
    logic [5:0]        clr_user_top;
    logic              clr_self;
    logic [3:0]        clr_user_mid;
    logic              clr_wake_sleep;
    logic              clr_event_q;
    logic              clr_sample_q;
    logic              clr_frame_cnt;
    logic [1:0]        clr_user_low;
    logic              clr_tilt;
    logic              clr_tap;
    logic              clr_low_accel;
    logic              clr_high_accel;
    logic              clr_orient;
    logic              clr_front_end;
    logic              clr_msg_box;
    logic              clr_gpio;
    logic              clr_cmd_parser;
    logic              clr_scheduler;
    logic              clr_general;
    acf_pkg::acf_vec_t clr_own;
    logic              flag_clear_all;
    acf_pkg::acf_vec_t flag_kept;
    acf_pkg::acf_vec_t flag_next;
    acf_pkg::acf_vec_t flag_reg;
    logic [7:0]        rd_mux;
    logic [7:0]        rdata_reg;

    assign sel = acf_decode(reg_addr);

    // -----------------------------------------------------------------
    // vector bytes
    // -----------------------------------------------------------------
    assign wr_byte3 = reg_wr && (sel == acf_pkg::ACF_SEL_BYTE3);
    assign wr_byte2 = reg_wr && (sel == acf_pkg::ACF_SEL_BYTE2);
    assign wr_byte1 = reg_wr && (sel == acf_pkg::ACF_SEL_BYTE1);
    assign wr_byte0 = reg_wr && (sel == acf_pkg::ACF_SEL_BYTE0);

    // unmapped offsets fall through and leave every byte untouched
    assign clear_vector_byte3_next = wr_byte3 ? reg_wdata : clear_vector_byte3_reg;
    assign clear_vector_byte2_next = wr_byte2 ? reg_wdata : clear_vector_byte2_reg;
    assign clear_vector_byte1_next = wr_byte1 ? reg_wdata : clear_vector_byte1_reg;
    assign clear_vector_byte0_next = wr_byte0 ? reg_wdata : clear_vector_byte0_reg;

    assign vec_reg = {clear_vector_byte3_reg,
                      clear_vector_byte2_reg,
                      clear_vector_byte1_reg,
                      clear_vector_byte0_reg};

    // -----------------------------------------------------------------
    // per-application start pulses
    // -----------------------------------------------------------------
    // ones written this cycle; a written zero starts nothing
    assign wr_ones    = reg_wr ? acf_lane_place(sel, reg_wdata) : 32'h0000_0000;
    assign general_wr = wr_ones[`ACF_BIT_GENERAL];

    // general bit fans out to every application that exists
    assign start_req = general_wr ? `ACF_VALID_MASK : wr_ones;

    assign start_user_top   = start_req[`ACF_USER_TOP_HI:`ACF_USER_TOP_LO];
    assign start_self       = start_req[`ACF_BIT_SELF];
    assign start_user_mid   = start_req[`ACF_USER_MID_HI:`ACF_USER_MID_LO];
    assign start_wake_sleep = start_req[`ACF_BIT_WAKE_SLEEP];
    assign start_event_q    = start_req[`ACF_BIT_EVENT_Q];
    assign start_sample_q   = start_req[`ACF_BIT_SAMPLE_Q];
    assign start_frame_cnt  = start_req[`ACF_BIT_FRAME_CNT];
    assign start_user_low   = start_req[`ACF_USER_LOW_HI:`ACF_USER_LOW_LO];
    assign start_tilt       = start_req[`ACF_BIT_TILT];
    assign start_tap        = start_req[`ACF_BIT_TAP];
    assign start_low_accel  = start_req[`ACF_BIT_LOW_ACCEL];
    assign start_high_accel = start_req[`ACF_BIT_HIGH_ACCEL];
    assign start_orient     = start_req[`ACF_BIT_ORIENT];
    assign start_front_end  = start_req[`ACF_BIT_FRONT_END];
    assign start_msg_box    = start_req[`ACF_BIT_MSG_BOX];
    assign start_gpio       = start_req[`ACF_BIT_GPIO];
    assign start_cmd_parser = start_req[`ACF_BIT_CMD_PARSER];
    assign start_scheduler  = start_req[`ACF_BIT_SCHEDULER];
    assign start_general    = start_req[`ACF_BIT_GENERAL];

    // -----------------------------------------------------------------
    // start assembly
    // -----------------------------------------------------------------
    // reserved positions are never driven, whatever the host wrote there
    always_comb begin
        start_next                                     = 32'h0000_0000;
        start_next[`ACF_USER_TOP_HI:`ACF_USER_TOP_LO] = start_user_top;
        start_next[`ACF_BIT_SELF]                     = start_self;
        start_next[`ACF_USER_MID_HI:`ACF_USER_MID_LO] = start_user_mid;
        start_next[`ACF_BIT_WAKE_SLEEP]               = start_wake_sleep;
        start_next[`ACF_BIT_EVENT_Q]                  = start_event_q;
        start_next[`ACF_BIT_SAMPLE_Q]                 = start_sample_q;
        start_next[`ACF_BIT_FRAME_CNT]                = start_frame_cnt;
        start_next[`ACF_USER_LOW_HI:`ACF_USER_LOW_LO] = start_user_low;
        start_next[`ACF_BIT_TILT]                     = start_tilt;
        start_next[`ACF_BIT_TAP]                      = start_tap;
        start_next[`ACF_BIT_LOW_ACCEL]                = start_low_accel;
        start_next[`ACF_BIT_HIGH_ACCEL]               = start_high_accel;
        start_next[`ACF_BIT_ORIENT]                   = start_orient;
        start_next[`ACF_BIT_FRONT_END]                = start_front_end;
        start_next[`ACF_BIT_MSG_BOX]                  = start_msg_box;
        start_next[`ACF_BIT_GPIO]                     = start_gpio;
        start_next[`ACF_BIT_CMD_PARSER]               = start_cmd_parser;
        start_next[`ACF_BIT_SCHEDULER]                = start_scheduler;
        start_next[`ACF_BIT_GENERAL]                  = start_general;
    end

    // -----------------------------------------------------------------
    // per-application flag clears
    // -----------------------------------------------------------------
    // an own-bit host clear acts on the written ones of one byte only; a general bit write clears every flag
    assign clr_user_top   = wr_ones[`ACF_USER_TOP_HI:`ACF_USER_TOP_LO];
    assign clr_self       = wr_ones[`ACF_BIT_SELF];
    assign clr_user_mid   = wr_ones[`ACF_USER_MID_HI:`ACF_USER_MID_LO];
    assign clr_wake_sleep = wr_ones[`ACF_BIT_WAKE_SLEEP];
    assign clr_event_q    = wr_ones[`ACF_BIT_EVENT_Q];
    assign clr_sample_q   = wr_ones[`ACF_BIT_SAMPLE_Q];
    assign clr_frame_cnt  = wr_ones[`ACF_BIT_FRAME_CNT];
    assign clr_user_low   = wr_ones[`ACF_USER_LOW_HI:`ACF_USER_LOW_LO];
    assign clr_tilt       = wr_ones[`ACF_BIT_TILT];
    assign clr_tap        = wr_ones[`ACF_BIT_TAP];
    assign clr_low_accel  = wr_ones[`ACF_BIT_LOW_ACCEL];
    assign clr_high_accel = wr_ones[`ACF_BIT_HIGH_ACCEL];
    assign clr_orient     = wr_ones[`ACF_BIT_ORIENT];
    assign clr_front_end  = wr_ones[`ACF_BIT_FRONT_END];
    assign clr_msg_box    = wr_ones[`ACF_BIT_MSG_BOX];
    assign clr_gpio       = wr_ones[`ACF_BIT_GPIO];
    assign clr_cmd_parser = wr_ones[`ACF_BIT_CMD_PARSER];
    assign clr_scheduler  = wr_ones[`ACF_BIT_SCHEDULER];
    assign clr_general    = wr_ones[`ACF_BIT_GENERAL];

    always_comb begin
        clr_own                                     = 32'h0000_0000;
        clr_own[`ACF_USER_TOP_HI:`ACF_USER_TOP_LO] = clr_user_top;
        clr_own[`ACF_BIT_SELF]                     = clr_self;
        clr_own[`ACF_USER_MID_HI:`ACF_USER_MID_LO] = clr_user_mid;
        clr_own[`ACF_BIT_WAKE_SLEEP]               = clr_wake_sleep;
        clr_own[`ACF_BIT_EVENT_Q]                  = clr_event_q;
        clr_own[`ACF_BIT_SAMPLE_Q]                 = clr_sample_q;
        clr_own[`ACF_BIT_FRAME_CNT]                = clr_frame_cnt;
        clr_own[`ACF_USER_LOW_HI:`ACF_USER_LOW_LO] = clr_user_low;
        clr_own[`ACF_BIT_TILT]                     = clr_tilt;
        clr_own[`ACF_BIT_TAP]                      = clr_tap;
        clr_own[`ACF_BIT_LOW_ACCEL]                = clr_low_accel;
        clr_own[`ACF_BIT_HIGH_ACCEL]               = clr_high_accel;
        clr_own[`ACF_BIT_ORIENT]                   = clr_orient;
        clr_own[`ACF_BIT_FRONT_END]                = clr_front_end;
        clr_own[`ACF_BIT_MSG_BOX]                  = clr_msg_box;
        clr_own[`ACF_BIT_GPIO]                     = clr_gpio;
        clr_own[`ACF_BIT_CMD_PARSER]               = clr_cmd_parser;
        clr_own[`ACF_BIT_SCHEDULER]                = clr_scheduler;
        clr_own[`ACF_BIT_GENERAL]                  = clr_general;
    end

    // -----------------------------------------------------------------
    // application flags
    // -----------------------------------------------------------------
    // set beats clear so a flag raised during a host clear survives
    assign flag_clear_all = wake_event || general_wr;
    assign flag_kept      = flag_clear_all ? 32'h0000_0000 : (flag_reg & ~clr_own);
    assign flag_next      = flag_kept | app_flag_set;

    // -----------------------------------------------------------------
    // read path
    // -----------------------------------------------------------------
    // idle or unmapped reads return zero so stale data never lingers
    assign rd_mux = reg_rd ? acf_lane_pick(sel, vec_reg) : 8'h00;

    // -----------------------------------------------------------------
    // vector byte registers
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            clear_vector_byte3_reg <= `ACF_RST_BYTE3;
        end else begin
            clear_vector_byte3_reg <= clear_vector_byte3_next;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            clear_vector_byte2_reg <= `ACF_RST_BYTE2;
        end else begin
            clear_vector_byte2_reg <= clear_vector_byte2_next;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            clear_vector_byte1_reg <= `ACF_RST_BYTE1;
        end else begin
            clear_vector_byte1_reg <= clear_vector_byte1_next;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            clear_vector_byte0_reg <= `ACF_RST_BYTE0;
        end else begin
            clear_vector_byte0_reg <= clear_vector_byte0_next;
        end
    end

    // -----------------------------------------------------------------
    // start pulse register
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            start_reg <= 32'h0000_0000;
        end else begin
            start_reg <= start_next;
        end
    end

    // -----------------------------------------------------------------
    // flag register
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flag_reg <= 32'h0000_0000;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // -----------------------------------------------------------------
    // read data register
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rd_mux;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign reg_rdata = rdata_reg;
    assign seq_start = start_reg;
    assign app_flag  = flag_reg;

endmodule : acf_clear_bank

// ### test/acf_clear_bank_checker.sv
// port checker of the clear vector bank
// assumes bind onto acf_clear_bank, one clock
`timescale 1ns/1ps
module acf_clear_bank_checker #(
    parameter int ADDR_W = 8
) (
    input wire logic              clk_sys,
    input wire logic              rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       app_flag_set,
    input wire logic              wake_event,
    input wire logic [7:0]        reg_rdata,
    input wire logic [31:0]       seq_start,
    input wire logic [31:0]       app_flag
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire w3 = reg_wr && reg_addr == 8'h08;
    wire w2 = reg_wr && reg_addr == 8'h09;
    wire w1 = reg_wr && reg_addr == 8'h10;
    wire w0 = reg_wr && reg_addr == 8'h11;
    // a cycle after no read strobe must not leave stale data on the port
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata");
    a_byte3_start: assert property (w3 |=> seq_start == {$past(reg_wdata) & 8'h3F, 24'h0}) else $error("b3");
    a_byte2_start: assert property (w2 |=> seq_start == {8'h0, $past(reg_wdata) & 8'hFD, 16'h0}) else $error("b2");
    a_byte1_start: assert property (w1 |=> seq_start == {16'h0, $past(reg_wdata), 8'h0}) else $error("b1");
    a_byte0_start: assert property (w0 && !reg_wdata[0] |=> seq_start == {24'h0, $past(reg_wdata) & 8'hDE})
        else $error("b0");
    a_general_all: assert property (w0 && reg_wdata[0] |=> seq_start == 32'h3FFD_FFDF) else $error("gen");
    a_wake_clear: assert property (wake_event && app_flag_set == 0 |=> app_flag == 0) else $error("wake");
    a_own_clear: assert property (w1 && app_flag_set == 0 |=> (app_flag & {16'h0, $past(reg_wdata), 8'h0}) == 0)
        else $error("own");
    a_set_wins: assert property (app_flag_set != 32'h0 |=>
        (app_flag & $past(app_flag_set)) == $past(app_flag_set)) else $error("set");
    a_start_idle: assert property (!$past(reg_wr) |-> seq_start == 32'h0) else $error("start");
endmodule : acf_clear_bank_checker

// ### test/acf_clear_bank_bench.sv
// self-checking bench of the clear vector bank
// assumes the checker file is compiled first
`timescale 1ns/1ps
module acf_clear_bank_bench;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] app_flag_set = 32'h0;
    logic        wake_event = 1'b0;
    logic [7:0]  reg_rdata;
    logic [31:0] seq_start;
    logic [31:0] app_flag;
    int          fail_count = 0;
    int          compares = 0;
    acf_clear_bank dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .app_flag_set(app_flag_set), .wake_event(wake_event), .reg_rdata(reg_rdata),
        .seq_start(seq_start), .app_flag(app_flag));
    initial forever #4 clk_sys = ~clk_sys;
    task automatic conclude;
        if (fail_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [31:0] s);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1 chk(seq_start, s);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk({24'h0, reg_rdata}, {24'h0, e});
    endtask : rd
    task automatic flags(input logic [31:0] v);
        @(posedge clk_sys);
        app_flag_set <= v;
        @(posedge clk_sys);
        app_flag_set <= 32'h0;
        #1 chk(app_flag, v);
    endtask : flags
    // watchdog: the run is under fifty cycles
    initial begin
        #100000;
        fail_count++;
        conclude;
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        rd(8'h09, 8'h7F);
        rd(8'h10, 8'hFF);
        rd(8'h11, 8'hFF);
        rd(8'h0A, 8'h00);
        wr(8'h08, 8'hFF, 32'h3F00_0000);
        wr(8'h09, 8'hFF, 32'h00FD_0000);
        wr(8'h10, 8'hFF, 32'h0000_FF00);
        wr(8'h11, 8'hFE, 32'h0000_00DE);
        wr(8'h11, 8'h01, 32'h3FFD_FFDF);
        wr(8'h08, 8'hC0, 32'h0);
        wr(8'h0A, 8'h55, 32'h0);
        rd(8'h08, 8'hC0);
        rd(8'h11, 8'h01);
        flags(32'h0000_C003);
        wr(8'h10, 8'h40, 32'h0000_4000);
        chk(app_flag, 32'h0000_8003);
        wr(8'h11, 8'h01, 32'h3FFD_FFDF);
        chk(app_flag, 32'h0);
        flags(32'h0000_4001);
        @(posedge clk_sys);
        app_flag_set <= 32'h0000_4000;
        reg_wr <= 1'b1;
        reg_addr <= 8'h10;
        reg_wdata <= 8'h40;
        @(posedge clk_sys);
        app_flag_set <= 32'h0;
        reg_wr <= 1'b0;
        #1 chk(app_flag, 32'h0000_4001);
        chk(seq_start, 32'h0000_4000);
        @(posedge clk_sys);
        wake_event <= 1'b1;
        @(posedge clk_sys);
        wake_event <= 1'b0;
        #1 chk(app_flag, 32'h0);
        flags(32'h0000_0600);
        @(posedge clk_sys);
        rst <= 1'b1;
        @(posedge clk_sys);
        rst <= 1'b0;
        #1 chk(app_flag, 32'h0);
        rd(8'h08, 8'hFF);
        conclude;
    end
endmodule : acf_clear_bank_bench
bind acf_clear_bank acf_clear_bank_checker #(.ADDR_W(ADDR_W)) u_chk (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .app_flag_set(app_flag_set),
    .wake_event(wake_event), .reg_rdata(reg_rdata), .seq_start(seq_start), .app_flag(app_flag));
